// *** logic/sdeat_pkg.sv ***
// Package with constants and types for the error alert timing block
package sdeat_pkg;

   // ---------------------------------------------------------------
   // Clock
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;

   // ---------------------------------------------------------------
   // Write leveling waits (kept by the controller, in clock cycles)
   // ---------------------------------------------------------------
   localparam int LEVELING_STROBE_ENABLE_WAIT = 25;
   localparam int LEVELING_FIRST_EDGE_WAIT = 40;

   // ---------------------------------------------------------------
   // Command/address parity
   // ---------------------------------------------------------------
   localparam logic [2:0] PARITY_LATENCY_2133 = 3'h4;
   localparam logic [2:0] PARITY_LATENCY_2400 = 3'h5;
   // Extra time on top of the parity latency, longest, so round down
   localparam int PARITY_ALERT_EXTRA_NS = 6;
   localparam int PARITY_ALERT_EXTRA_CYC_RAW = (PARITY_ALERT_EXTRA_NS * 1000) / CLK_PERIOD_PS;
   localparam int PARITY_ALERT_EXTRA_CYC =
      (PARITY_ALERT_EXTRA_CYC_RAW < 1) ? 1 : PARITY_ALERT_EXTRA_CYC_RAW;
   localparam int PAR_PW_MIN_2133 = 64;
   localparam int PAR_PW_MAX_2133 = 128;
   localparam int PAR_PW_MIN_2400 = 72;
   localparam int PAR_PW_MAX_2400 = 114;
   // Pulse sits mid-range so a controller sees margin on both sides
   localparam logic [7:0] PAR_PW_2133 = 8'((PAR_PW_MIN_2133 + PAR_PW_MAX_2133) / 2);
   localparam logic [7:0] PAR_PW_2400 = 8'((PAR_PW_MIN_2400 + PAR_PW_MAX_2400) / 2);
   localparam logic [7:0] PAR_RSP_2133 = 8'h39;
   localparam logic [7:0] PAR_RSP_2400 = 8'h40;

   // ---------------------------------------------------------------
   // Write data CRC
   // ---------------------------------------------------------------
   localparam int CRC_ALERT_DELAY_MIN_NS = 3;
   localparam int CRC_ALERT_DELAY_MAX_NS = 13;
   localparam int CRC_ALERT_DELAY_MIN_CYC =
      (CRC_ALERT_DELAY_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CRC_ALERT_DELAY_MAX_CYC = (CRC_ALERT_DELAY_MAX_NS * 1000) / CLK_PERIOD_PS;
   localparam int CRC_PW_MIN = 6;
   localparam int CRC_PW_MAX = 10;
   localparam logic [7:0] CRC_PW = 8'((CRC_PW_MIN + CRC_PW_MAX) / 2);

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic cs_n;
      logic act_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [1:0] bg;
      logic [1:0] ba;
      logic [17:0] addr;
      logic par;
   } sdeat_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PAR_WAIT,
      ST_PAR_ALERT,
      ST_CRC_ALERT
   } sdeat_state_t;

endpackage

// *** logic/sdeat_delay_line.sv ***
// Command delay line with a selectable tap
`timescale 1ns/1ps
module sdeat_delay_line #(
   parameter int DEPTH = 5
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Incoming command
   input wire logic in_valid,
   input wire sdeat_pkg::sdeat_cmd_t in_cmd,
   // Tap select, 1 to DEPTH stages
   input wire logic [2:0] tap,
   // Delayed command
   output sdeat_pkg::sdeat_cmd_t tap_cmd,
   output logic tap_valid
);

   initial begin
      if (DEPTH < 1 || DEPTH > 7) begin
         $error("sdeat_delay_line: DEPTH must be 1 to 7");
      end
   end

   sdeat_pkg::sdeat_cmd_t stage_cmd [DEPTH];
   logic [DEPTH-1:0] stage_valid;

   // ---------------------------------------------------------------
   // Stages
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : gen_stage
         sdeat_pkg::sdeat_cmd_t prev_cmd;
         logic prev_valid;
         // First stage takes the input; no index below zero is ever formed
         if (g == 0) begin : gen_first
            assign prev_cmd = in_cmd;
            assign prev_valid = in_valid;
         end else begin : gen_next
            assign prev_cmd = stage_cmd[g-1];
            assign prev_valid = stage_valid[g-1];
         end
         // Each stage copies the one before it
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               stage_cmd[g] <= '0;
               stage_valid[g] <= 1'b0;
            end else begin
               stage_cmd[g] <= prev_cmd;
               stage_valid[g] <= prev_valid;
            end
         end
      end
   endgenerate

   // Tap mux; out-of-range taps give the deepest stage
   always_comb begin
      tap_cmd = stage_cmd[DEPTH-1];
      tap_valid = stage_valid[DEPTH-1];
      for (int i = 0; i < DEPTH; i++) begin
         if (tap == 3'(i + 1)) begin
            tap_cmd = stage_cmd[i];
            tap_valid = stage_valid[i];
         end
      end
   end

endmodule

// *** logic/sdeat_alert_ctrl.sv ***
// Parity and write-CRC error alert logic of the memory device
//
// Function
// [R1] The controller waits at least 25 cycles after entering write leveling before driving strobes.
// [R2] Parity latency is 4 cycles (2133) or 5 (2400) and commands inside it may not execute.
// [R3] A command with bad parity raises the alert no later than parity latency plus 6 ns.
// [R4] A parity alert lasts 64 to 128 cycles (2133) or 72 to 114 cycles (2400).
// [R5] In persistent mode the controller sends deselects within 57 (2133) or 64 (2400) cycles.
// [R6] A write CRC error raises the alert between 3 ns and 13 ns after it is seen.
// [R7] A write CRC alert lasts 6 to 10 cycles, shorter than a parity alert.
// [R8] The controller gives no first rising strobe edge before 40 cycles into write leveling.
// [R9] The controller tells the two alert kinds apart by pulse length and retries; the host model measures pulse_len but never retries.
`timescale 1ns/1ps
module sdeat_alert_ctrl #(
   parameter int CNT_W = 8,
   parameter int MAX_PL = 5
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Configuration
   input wire logic grade_2400,
   input wire logic persistent_mode,
   // Command from the controller, one per clock
   input wire sdeat_pkg::sdeat_cmd_t cmd_in,
   // Write data CRC mismatch, one-cycle pulse
   input wire logic crc_err,
   // Clears the sticky parity flag
   input wire logic err_clear,
   // Commands passed on to the core
   output sdeat_pkg::sdeat_cmd_t core_cmd,
   output logic core_cmd_valid,
   // Shared alert pin, active low
   output logic alert_n,
   // Status
   output logic parity_err_seen,
   output logic des_violation
);

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   initial begin
      if (CNT_W < 8) begin
         $error("sdeat_alert_ctrl: CNT_W too small for the parity pulse");
      end
      if (MAX_PL < 5) begin
         $error("sdeat_alert_ctrl: MAX_PL must cover a parity latency of 5");
      end
      if (MAX_PL > 7) begin
         $error("sdeat_alert_ctrl: MAX_PL must fit the 3-bit tap select");
      end
   end

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   // Even parity over every command/address bit and the parity bit
   // Chip select is left out: a deselect carries no parity
   function automatic logic parity_ok(input sdeat_pkg::sdeat_cmd_t c);
      logic [25:0] bits;
      bits = {c.act_n, c.ras_n, c.cas_n, c.we_n, c.bg, c.ba, c.addr};
      return (^bits) == c.par;
   endfunction

   sdeat_pkg::sdeat_state_t state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] rsp_cnt;
   logic [2:0] parity_latency;
   logic [CNT_W-1:0] par_pw;
   logic [CNT_W-1:0] par_rsp;
   logic cmd_sel;
   logic par_bad;
   logic in_keep;
   sdeat_pkg::sdeat_cmd_t tap_cmd;
   logic tap_valid;

   // Grade-dependent figures
   assign parity_latency = grade_2400 ? sdeat_pkg::PARITY_LATENCY_2400 :
                                        sdeat_pkg::PARITY_LATENCY_2133; // R2
   assign par_pw = grade_2400 ? CNT_W'(sdeat_pkg::PAR_PW_2400) :
                                CNT_W'(sdeat_pkg::PAR_PW_2133); // R4
   assign par_rsp = grade_2400 ? CNT_W'(sdeat_pkg::PAR_RSP_2400) :
                                 CNT_W'(sdeat_pkg::PAR_RSP_2133); // R5

   // Parity is only checked on selected commands; deselects carry none.
   // Checking pauses while a parity error is in flight, as one alert covers it.
   assign cmd_sel = !cmd_in.cs_n;
   assign par_bad = cmd_sel && !parity_ok(cmd_in) &&
                    (state != sdeat_pkg::ST_PAR_WAIT) && (state != sdeat_pkg::ST_PAR_ALERT);

   // Errant command and everything up to the alert's end are dropped
   assign in_keep = cmd_sel && !par_bad &&
                    (state != sdeat_pkg::ST_PAR_WAIT) &&
                    (state != sdeat_pkg::ST_PAR_ALERT); // R2

   // ---------------------------------------------------------------
   // Command pipeline
   // ---------------------------------------------------------------
   // Commands reach the core after the parity latency, so an error
   // can still be acted on before anything executes.
   sdeat_delay_line #(
      .DEPTH(MAX_PL)
   ) u_delay (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .in_valid(in_keep),
      .in_cmd(cmd_in),
      .tap(parity_latency),
      .tap_cmd(tap_cmd),
      .tap_valid(tap_valid)
   );

   // Output register toward the core; pipe is flushed on a parity error
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         core_cmd <= '0;
         core_cmd_valid <= 1'b0;
      end else begin
         core_cmd <= tap_cmd;
         core_cmd_valid <= tap_valid && (state != sdeat_pkg::ST_PAR_WAIT) && !par_bad; // R2
      end
   end

   // ---------------------------------------------------------------
   // Alert sequencer
   // ---------------------------------------------------------------
   // A parity error overrides a CRC pulse in progress; a CRC error
   // during a parity error is absorbed by the longer pulse.
   // The wait counter is loaded with PL plus the rounded-down extra time less one, so the
   // pin falls PL+1 edges after the errant command, inside PL plus 6 ns.
   // Limitation: a parity error inside a CRC pulse keeps the pin low from
   // the CRC edge on, so the pin pulse is longer than the parity pulse.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= sdeat_pkg::ST_IDLE;
         cnt <= '0;
         alert_n <= 1'b1;
      end else begin
         case (state)
            sdeat_pkg::ST_IDLE, sdeat_pkg::ST_CRC_ALERT: begin
               if (par_bad) begin
                  state <= sdeat_pkg::ST_PAR_WAIT;
                  cnt <= CNT_W'(parity_latency) +
                         CNT_W'(sdeat_pkg::PARITY_ALERT_EXTRA_CYC - 1); // R3
               end else if (crc_err) begin
                  // Registered straight from the error: one cycle, inside 3 to 13 ns
                  state <= sdeat_pkg::ST_CRC_ALERT;
                  alert_n <= 1'b0; // R6
                  cnt <= CNT_W'(sdeat_pkg::CRC_PW) - CNT_W'(1); // R7
               end else if (state == sdeat_pkg::ST_CRC_ALERT) begin
                  if (cnt == '0) begin
                     state <= sdeat_pkg::ST_IDLE;
                     alert_n <= 1'b1; // R7
                  end else begin
                     cnt <= cnt - CNT_W'(1);
                  end
               end
            end
            sdeat_pkg::ST_PAR_WAIT: begin
               if (cnt == '0) begin
                  state <= sdeat_pkg::ST_PAR_ALERT;
                  alert_n <= 1'b0; // R3
                  cnt <= par_pw - CNT_W'(1); // R4
               end else begin
                  cnt <= cnt - CNT_W'(1);
               end
            end
            sdeat_pkg::ST_PAR_ALERT: begin
               if (cnt == '0) begin
                  state <= sdeat_pkg::ST_IDLE;
                  alert_n <= 1'b1; // R4
               end else begin
                  cnt <= cnt - CNT_W'(1);
               end
            end
            default: begin
               state <= sdeat_pkg::ST_IDLE;
               alert_n <= 1'b1;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Status
   // ---------------------------------------------------------------
   // Sticky parity flag; a new error wins over a clear in the same cycle
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         parity_err_seen <= 1'b0;
      end else if (par_bad) begin
         parity_err_seen <= 1'b1;
      end else if (err_clear) begin
         parity_err_seen <= 1'b0;
      end
   end

   // Cycles since the parity alert went low; saturates
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rsp_cnt <= '0;
      end else if (state != sdeat_pkg::ST_PAR_ALERT) begin
         rsp_cnt <= '0;
      end else if (rsp_cnt != '1) begin
         rsp_cnt <= rsp_cnt + CNT_W'(1);
      end
   end

   // Flags a selected command once the controller should be sending deselects.
   // Only a diagnostic: the command is dropped either way.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         des_violation <= 1'b0;
      end else begin
         des_violation <= persistent_mode && cmd_sel &&
                          (state == sdeat_pkg::ST_PAR_ALERT) && (rsp_cnt >= par_rsp); // R5
      end
   end

endmodule

// *** dv/sdeat_alert_assertions.sv ***
// Checker for alert and command timing at the alert block's ports
`timescale 1ns/1ps
module sdeat_alert_assertions (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Inputs
   input wire logic grade_2400,
   input wire logic persistent_mode,
   input wire sdeat_pkg::sdeat_cmd_t cmd_in,
   input wire logic crc_err,
   // Outputs
   input wire sdeat_pkg::sdeat_cmd_t core_cmd,
   input wire logic core_cmd_valid,
   input wire logic alert_n,
   input wire logic parity_err_seen,
   input wire logic des_violation
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   logic [7:0] low_cnt;
   logic bad;
   logic des_due;
   // Bad parity on a selected command
   assign bad = !cmd_in.cs_n && ((^cmd_in[26:1]) != cmd_in.par);
   assign des_due = persistent_mode && !cmd_in.cs_n && !alert_n && parity_err_seen
      && (low_cnt >= (grade_2400 ? 8'h40 : 8'h39));
   // Counts low edges; zero on the first low edge, like the device counter
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) low_cnt <= 8'h00;
      else if (alert_n) low_cnt <= 8'h00;
      else low_cnt <= low_cnt + 8'h01;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_cmd_delay_slow: assert property (core_cmd_valid && !grade_2400 |->
      core_cmd == $past(cmd_in, 5) && !core_cmd.cs_n) else $error("late or wrong command");
   a_cmd_delay_fast: assert property (core_cmd_valid && grade_2400 |->
      core_cmd == $past(cmd_in, 6) && (^core_cmd[26:1]) == core_cmd.par)
      else $error("late or wrong command");
   a_par_alert_on: assert property (bad && alert_n && !parity_err_seen |=>
      if (grade_2400) ((parity_err_seen && alert_n)[*6] ##1 !alert_n)
      else ((parity_err_seen && alert_n)[*5] ##1 !alert_n))
      else $error("parity alert timing");
   a_par_pulse_width: assert property ($rose(alert_n) && parity_err_seen |->
      low_cnt == (grade_2400 ? 8'h5D : 8'h60)) else $error("parity pulse width");
   a_crc_pulse_width: assert property ($rose(alert_n) && !parity_err_seen |->
      low_cnt inside {[8'h06:8'h0A]}) else $error("crc pulse width");
   a_crc_alert_on: assert property (crc_err && alert_n && !parity_err_seen && !bad
      |=> !alert_n) else $error("crc alert late");
   a_no_exec_alert: assert property (!alert_n && parity_err_seen |->
      !core_cmd_valid) else $error("command ran in parity error");
   a_des_flag_cause: assert property (des_violation |-> $past(des_due))
      else $error("spurious deselect flag");
   a_des_flag_raise: assert property (des_due |=> des_violation)
      else $error("missing deselect flag");
   c_par: cover property ($rose(alert_n) && parity_err_seen);
   c_crc: cover property ($rose(alert_n) && !parity_err_seen);
   c_des: cover property (des_violation);
endmodule

bind sdeat_alert_ctrl sdeat_alert_assertions i_chk (.ref_clk, .arst_n, .grade_2400,
   .persistent_mode, .cmd_in, .crc_err, .core_cmd, .core_cmd_valid, .alert_n,
   .parity_err_seen, .des_violation);

// *** dv/sdeat_host_model.sv ***
// Controller-side model: issues commands and times alert pulses
`timescale 1ns/1ps
module sdeat_host_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Requests from the bench
   input wire logic req_valid,
   input wire sdeat_pkg::sdeat_cmd_t req_cmd,
   input wire logic persistent_mode,
   input wire logic force_cmd,
   // Device side
   input wire logic alert_n,
   output sdeat_pkg::sdeat_cmd_t cmd_out,
   // Measured alert pulse
   output logic [7:0] pulse_len,
   output logic pulse_done,
   // Write leveling strobe timing after reset
   output logic strobe_drive,
   output logic strobe_rise
);
   logic [7:0] run;
   logic [7:0] lvl_cnt;
   // Deselects during a persistent alert; idle lines toggle so no stale value shows
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) cmd_out <= {1'b1, 27'h0};
      else if (req_valid && (alert_n || !persistent_mode || force_cmd))
         cmd_out <= #1 req_cmd;
      else cmd_out <= #1 {1'b1, ~cmd_out[26:0]};
   end
   // Leveling entered at reset release; strobes stay parked until the waits run out
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lvl_cnt <= 8'h00;
         strobe_drive <= 1'b0;
         strobe_rise <= 1'b0;
      end else begin
         if (lvl_cnt != 8'hFF) lvl_cnt <= lvl_cnt + 8'h01;
         strobe_drive <= strobe_drive ||
            (lvl_cnt >= 8'(sdeat_pkg::LEVELING_STROBE_ENABLE_WAIT));
         strobe_rise <= (lvl_cnt == 8'(sdeat_pkg::LEVELING_FIRST_EDGE_WAIT));
      end
   end
   // Pulse length tells a parity alert (long) from a crc alert (short)
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         run <= 8'h00;
         pulse_done <= 1'b0;
         pulse_len <= 8'h00;
      end else begin
         pulse_done <= alert_n && (run != 8'h00);
         if (alert_n) pulse_len <= run;
         run <= alert_n ? 8'h00 : run + 8'h01;
      end
   end
endmodule

// *** dv/sdeat_alert_ctrl_tb.sv ***
// Self-checking bench for the alert block with a controller model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin n_mismatch++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module sdeat_alert_ctrl_tb;
   logic ref_clk, arst_n, grade_2400, persistent_mode, crc_err, err_clear;
   logic req_valid, force_cmd, core_cmd_valid, alert_n, parity_err_seen, des_violation;
   logic pulse_done, strobe_drive, strobe_rise;
   logic [7:0] pulse_len;
   sdeat_pkg::sdeat_cmd_t req_cmd, cmd_in, core_cmd, ec;
   sdeat_pkg::sdeat_cmd_t q_cmd[$];
   logic [7:0] q_pw[$];
   logic [7:0] ep;
   int n_mismatch = 0, cmp_count = 0, n_des = 0, lvl_cyc = 0, n_rise = 0;

   sdeat_alert_ctrl i_dut (.ref_clk, .arst_n, .grade_2400, .persistent_mode, .cmd_in,
      .crc_err, .err_clear, .core_cmd, .core_cmd_valid, .alert_n, .parity_err_seen,
      .des_violation);
   sdeat_host_model i_host (.ref_clk, .arst_n, .req_valid, .req_cmd, .persistent_mode,
      .force_cmd, .alert_n, .cmd_out(cmd_in), .pulse_len, .pulse_done, .strobe_drive,
      .strobe_rise);

   // ----------------------------------------
   // Clock, tasks, watcher
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Random command; parity bit spoiled when good is low
   task automatic send(input logic good, input logic keep);
      sdeat_pkg::sdeat_cmd_t c;
      c = 28'($urandom);
      c.cs_n = 1'b0;
      c.par = (^c[26:1]) ^ !good;
      req_cmd = c;
      req_valid = 1'b1;
      if (keep) q_cmd.push_back(c);
      tick(1);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Results are taken once the edge's updates have landed
   always @(posedge ref_clk) begin
      #2;
      if (core_cmd_valid === 1'b1) begin
         ec = q_cmd.size() ? q_cmd.pop_front() : 'x;
         `CHK("core_cmd", ec, core_cmd)
      end
      if (pulse_done === 1'b1) begin
         ep = q_pw.size() ? q_pw.pop_front() : 'x;
         `CHK("alert_pulse", ep, pulse_len)
      end
      if (des_violation === 1'b1) n_des++;
      // Leveling waits of the controller model, counted from reset release
      if (arst_n !== 1'b1) lvl_cyc = 0;
      else lvl_cyc++;
      if (lvl_cyc > 0 && lvl_cyc <= sdeat_pkg::LEVELING_STROBE_ENABLE_WAIT)
         `CHK("strobe_early", 1'b0, strobe_drive)
      if (strobe_rise === 1'b1) begin
         n_rise++;
         `CHK("strobe_drive", 1'b1, strobe_drive)
         `CHK("first_edge_wait", 1'b1, lvl_cyc >= sdeat_pkg::LEVELING_FIRST_EDGE_WAIT)
      end
   end
   // Watchdog, far beyond the roughly 360 cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      tally_and_finish();
   end

   // ----------------------------------------
   // Main sequence, both speed grades
   // ----------------------------------------
   initial begin
      void'($urandom(32'h7ab3));
      {arst_n, crc_err, err_clear, req_valid, force_cmd, grade_2400} = 6'h00;
      persistent_mode = 1'b1;
      req_cmd = '0;
      for (int g = 0; g < 2; g++) begin
         arst_n = 1'b0;
         grade_2400 = g[0];
         tick(5);
         arst_n = 1'b1;
         tick(1);
         // Back-to-back commands with random gaps
         repeat (20) begin
            if ($urandom % 4 == 0) begin
               req_valid = 1'b0;
               tick(1);
            end else send(1'b1, 1'b1);
         end
         req_valid = 1'b0;
         tick(10);
         // Single crc error, then a restarted one
         crc_err = 1'b1;
         q_pw.push_back(8'h08);
         tick(1);
         crc_err = 1'b0;
         tick(14);
         crc_err = 1'b1;
         q_pw.push_back(8'h09);
         tick(2);
         crc_err = 1'b0;
         tick(14);
         // Parity error; following commands and a crc error are ignored
         q_pw.push_back(g ? 8'h5D : 8'h60);
         send(1'b0, 1'b0);
         repeat (3) send(1'b1, 1'b0);
         req_valid = 1'b0;
         tick(20);
         crc_err = 1'b1;
         tick(1);
         crc_err = 1'b0;
         tick(60);
         // Late command with persistent mode off is not flagged
         persistent_mode = 1'b0;
         send(1'b1, 1'b0);
         req_valid = 1'b0;
         tick(1);
         persistent_mode = 1'b1;
         // Command instead of deselect late in a persistent alert
         force_cmd = 1'b1;
         send(1'b1, 1'b0);
         req_valid = 1'b0;
         force_cmd = 1'b0;
         for (int i = 0; i < 200 && alert_n !== 1'b1; i++) tick(1);
         `CHK("alert_n", 1'b1, alert_n)
         `CHK("parity_err_seen", 1'b1, parity_err_seen)
         err_clear = 1'b1;
         send(1'b1, 1'b1);
         err_clear = 1'b0;
         req_valid = 1'b0;
         tick(10);
         `CHK("parity_err_seen", 1'b0, parity_err_seen)
      end
      `CHK("des_count", 2, n_des)
      `CHK("rise_count", 2, n_rise)
      `CHK("cmd_left", 0, q_cmd.size())
      `CHK("pulse_left", 0, q_pw.size())
      tally_and_finish();
   end
endmodule
